// *** dv/mem_model.sv ***
// Purpose: Word-wide memory with byte lanes on the far side of the core bus
// Assumes: Read data answers in the same cycle as the read strobe
// Notes: 256 words; the bench preloads programs through the array
`timescale 1ns/100ps
`default_nettype none
module mem_model (
	// Clock
	input wire logic i_ref_clk,
	// Bus from the core
	input wire logic [15:0] i_mem_addr,
	input wire logic [15:0] i_mem_wdata,
	input wire logic [1:0] i_mem_be,
	input wire logic i_mem_rd,
	input wire logic i_mem_wr,
	// Read data to the core
	output logic [15:0] o_mem_rdata
);
	logic [15:0] mem [0:255];
	logic [7:0] idx;

	assign idx = i_mem_addr[8:1];
	// Answers only while selected; otherwise shows a changed value
	assign o_mem_rdata = i_mem_rd ? mem[idx] : ~mem[idx];

	// Writes commit on the edge that ends the strobe cycle, lane by lane
	always @(posedge i_ref_clk) begin
		if (i_mem_wr) begin
			if (i_mem_be[0]) begin
				mem[idx][7:0] <= i_mem_wdata[7:0];
			end
			if (i_mem_be[1]) begin
				mem[idx][15:8] <= i_mem_wdata[15:8];
			end
		end
	end
endmodule
`default_nettype wire

// *** dv/risc16_cpu_core_operand_modes_tb.sv ***
// Purpose: Self-checking bench for the 16-bit core and its operand modes
// Assumes: Programs run from word 0 after reset; results are stored to memory
// Notes: Only clock and reset are driven by the bench; the memory model answers the bus
`timescale 1ns/100ps
`default_nettype none
module risc16_cpu_core_operand_modes_tb;
	import cpu_pkg::*;
	logic i_ref_clk;
	logic i_resetn;
	logic [15:0] rdata;
	logic [15:0] addr;
	logic [15:0] wdata;
	logic [1:0] be;
	logic rd;
	logic wr;
	int fails;
	int num_checks;

	cpu_core u_cpu_core (
		.i_ref_clk(i_ref_clk),
		.i_resetn(i_resetn),
		.i_mem_rdata(rdata),
		.o_mem_addr(addr),
		.o_mem_wdata(wdata),
		.o_mem_be(be),
		.o_mem_rd(rd),
		.o_mem_wr(wr)
	);
	mem_model u_mem_model (
		.i_ref_clk(i_ref_clk),
		.i_mem_addr(addr),
		.i_mem_wdata(wdata),
		.i_mem_be(be),
		.i_mem_rd(rd),
		.i_mem_wr(wr),
		.o_mem_rdata(rdata)
	);

	initial i_ref_clk = 1'b0;
	always #4 i_ref_clk = ~i_ref_clk;

	task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
		num_checks++;
		if (seen !== exp) begin
			fails++;
			$display("[ERR] %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic wrap_up();
		if (fails == 0 && num_checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	function automatic logic [15:0] word_at(input logic [15:0] a);
		return u_mem_model.mem[a[8:1]];
	endfunction

	task automatic put(input logic [15:0] a, input logic [15:0] w);
		u_mem_model.mem[a[8:1]] = w;
	endtask

	// Holds reset, fills memory (idle loop in words 0..127, zero in 128..255) and checks idle bus
	task automatic hold_reset();
		@(posedge i_ref_clk);
		#1 i_resetn = 1'b0;
		for (int i = 0; i < 256; i++) begin
			u_mem_model.mem[i] = (i < 128) ? 16'h3FFF : 16'h0000;
		end
		repeat (12) @(posedge i_ref_clk);
		#1;
		check("reset_rd", {15'h0000, rd}, 16'h0000);
		check("reset_wr", {15'h0000, wr}, 16'h0000);
		check("reset_be", {14'h0000, be}, {14'h0000, BE_WORD});
	endtask

	task automatic release_run(input int cycles);
		i_resetn = 1'b1;
		repeat (cycles) @(posedge i_ref_clk);
		#1;
	endtask

	// Four register-to-register adds fetched on four consecutive cycles
	task automatic t_reg_timing();
		int c0;
		int c8;
		c0 = -1;
		c8 = -1;
		hold_reset();
		for (int i = 0; i < 8; i += 2) begin
			put(i[15:0], 16'h5404);
		end
		i_resetn = 1'b1;
		for (int c = 0; c < 20; c++) begin
			@(posedge i_ref_clk);
			#1;
			if (rd === 1'b1 && addr === 16'h0000) begin
				c0 = c;
			end
			if (rd === 1'b1 && addr === 16'h0008 && c8 < 0) begin
				c8 = c;
			end
		end
		check("rr_cycles", 16'(c8 - c0), 16'h0004);
		check("first_fetch", 16'(c0), 16'h0000);
	endtask

	// Immediate, absolute, byte, autoincrement, indexed and constant modes
	task automatic t_modes();
		hold_reset();
		put(16'h0000, 16'h4034);
		put(16'h0002, 16'h1234);
		put(16'h0004, 16'h4482);
		put(16'h0006, 16'h0100);
		put(16'h0008, 16'h5404);
		put(16'h000A, 16'h4482);
		put(16'h000C, 16'h0102);
		put(16'h000E, 16'h44C2);
		put(16'h0010, 16'h0105);
		put(16'h0012, 16'h4036);
		put(16'h0014, 16'h0100);
		put(16'h0016, 16'h4637);
		put(16'h0018, 16'h4682);
		put(16'h001A, 16'h0106);
		put(16'h001C, 16'h4782);
		put(16'h001E, 16'h0108);
		put(16'h0020, 16'h4692);
		put(16'h0022, 16'h0002);
		put(16'h0024, 16'h010A);
		put(16'h0026, 16'h4392);
		put(16'h0028, 16'h0112);
		// Indirect source, symbolic source, byte push and stack pointer store
		put(16'h002A, 16'h46A2);
		put(16'h002C, 16'h0114);
		put(16'h002E, 16'h4092);
		put(16'h0030, 16'h00D0);
		put(16'h0032, 16'h0116);
		put(16'h0034, 16'h4031);
		put(16'h0036, 16'h0180);
		put(16'h0038, 16'h1244);
		put(16'h003A, 16'h4182);
		put(16'h003C, 16'h0118);
		release_run(80);
		check("imm_abs", word_at(16'h0100), 16'h1234);
		check("add_wb", word_at(16'h0102), 16'h2468);
		check("byte_hi", word_at(16'h0104), 16'h6800);
		check("inc_reg", word_at(16'h0106), 16'h0102);
		check("inc_data", word_at(16'h0108), 16'h1234);
		check("indexed", word_at(16'h010A), 16'h6800);
		check("const_one", word_at(16'h0112), CG_ONE);
		check("indirect", word_at(16'h0114), 16'h2468);
		check("symbolic", word_at(16'h0116), 16'h1234);
		check("push_byte", word_at(16'h017E), 16'h0068);
		check("push_sp", word_at(16'h0118), 16'h017E);
	endtask

	// Not-equal jump untaken then taken, then a subroutine call
	task automatic t_flow();
		hold_reset();
		put(16'h0000, 16'h9404);
		put(16'h0002, 16'h2002);
		put(16'h0004, 16'h4392);
		put(16'h0006, 16'h010C);
		put(16'h0008, 16'h4314);
		put(16'h000A, 16'h9304);
		put(16'h000C, 16'h2002);
		put(16'h000E, 16'h4392);
		put(16'h0010, 16'h010E);
		put(16'h0012, 16'h4031);
		put(16'h0014, 16'h0200);
		put(16'h0016, 16'h4038);
		put(16'h0018, 16'h0040);
		put(16'h001A, 16'h1288);
		put(16'h0040, 16'h4482);
		put(16'h0042, 16'h0110);
		release_run(80);
		check("jne_equal", word_at(16'h010C), 16'h0001);
		check("jne_differ", word_at(16'h010E), 16'h0000);
		check("call_push", word_at(16'h01FE), 16'h001C);
		check("call_below", word_at(16'h01FC), 16'h0000);
		check("call_target", word_at(16'h0110), 16'h0001);
	endtask

	initial begin
		i_resetn = 1'b0;
		fails = 0;
		num_checks = 0;
		t_reg_timing();
		t_modes();
		t_flow();
		wrap_up();
	end

	// Cuts a hang short well beyond the few hundred cycles the tests need
	initial begin
		#160000;
		fails++;
		wrap_up();
	end
endmodule
`default_nettype wire

// *** src/alu16.sv ***
// Purpose: Word and byte arithmetic unit of the processor core
// Assumes: Operation codes from cpu_pkg
// Notes: Purely combinational
`timescale 1ns/100ps
`default_nettype none
module alu16 (
	// Operation
	input wire logic [3:0] i_op,
	input wire logic i_byte,
	input wire logic i_carry,
	// Operands
	input wire logic [15:0] i_src,
	input wire logic [15:0] i_dst,
	// Result
	output logic [15:0] o_res,
	output logic [3:0] o_flags,
	output logic o_flag_we,
	output logic o_wb
);
	import cpu_pkg::*;
	logic [15:0] msk, s, d, a, r, dec;
	logic [16:0] sum;
	logic [4:0] dig;
	logic cin, is_sub, c, v, dc, dec_c8, z, n;
	assign msk = i_byte ? 16'h00FF : 16'hFFFF;
	assign s = i_src & msk;
	assign d = i_dst & msk;
	assign is_sub = (i_op == OP_SUB) || (i_op == OP_SUBC) || (i_op == OP_CMP);
	assign a = is_sub ? (~s & msk) : s;
	assign cin = (i_op == OP_ADD) ? 1'b0 :
		((i_op == OP_SUB) || (i_op == OP_CMP)) ? 1'b1 : i_carry;
	assign sum = {1'b0, a} + {1'b0, d} + {16'h0000, cin};
	// Decimal add, nibble by nibble
	always_comb begin
		dig = 5'h00;
		dc = i_carry;
		dec = 16'h0000;
		dec_c8 = 1'b0;
		for (int i = 0; i < 4; i++) begin
			dig = {1'b0, s[4*i +: 4]} + {1'b0, d[4*i +: 4]} + {4'h0, dc};
			dc = dig > 5'h09;
			if (dc) begin
				dig = dig + 5'h06;
			end
			dec[4*i +: 4] = dig[3:0];
			if (i == 1) begin
				dec_c8 = dc;
			end
		end
	end
	always_comb begin
		r = 16'h0000;
		c = i_carry;
		v = 1'b0;
		case (i_op)
			OP_RRC: begin
				r = (d >> 1) | (i_byte ? {8'h00, i_carry, 7'h00} : {i_carry, 15'h0000});
				c = d[0];
			end
			OP_RRA: begin
				r = (d >> 1) | (i_byte ? {8'h00, d[7], 7'h00} : {d[15], 15'h0000});
				c = d[0];
			end
			OP_SWPB: r = {i_dst[7:0], i_dst[15:8]};
			OP_SXT: begin
				r = {{8{i_dst[7]}}, i_dst[7:0]};
				c = r != 16'h0000;
			end
			OP_MOVE: r = s;
			OP_DADD: begin
				r = dec;
				c = i_byte ? dec_c8 : dc;
			end
			OP_BIC: r = d & ~s;
			OP_BIS: r = d | s;
			OP_XOR: begin
				r = d ^ s;
				c = (r & msk) != 16'h0000;
				v = i_byte ? (s[7] & d[7]) : (s[15] & d[15]);
			end
			OP_AND, OP_BIT: begin
				r = d & s;
				c = (r & msk) != 16'h0000;
			end
			default: begin
				r = sum[15:0];
				c = i_byte ? sum[8] : sum[16];
				v = i_byte ? ((a[7] == d[7]) && (sum[7] != d[7])) :
					((a[15] == d[15]) && (sum[15] != d[15]));
			end
		endcase
	end
	assign o_res = r & msk;
	assign z = (r & msk) == 16'h0000;
	assign n = i_byte ? r[7] : r[15];
	assign o_flags = {v, n, z, c};
	assign o_flag_we = !((i_op == OP_MOVE) || (i_op == OP_BIC) || (i_op == OP_BIS) ||
		(i_op == OP_SWPB));
	assign o_wb = !((i_op == OP_CMP) || (i_op == OP_BIT));
endmodule
`default_nettype wire

// *** src/cpu_core.sv ***
// Purpose: 16-bit processor core with operand addressing-mode decoder
// Assumes: Memory answers a read with data in the same cycle as the request
// Notes: Reset vectoring and interrupts are outside this block
// What this block does
// - Sixteen 16-bit registers, 0 to 15, all addressable as operands.
// - Register-to-register instructions finish in one clock cycle.
// - Registers 0..3 are program counter, stack pointer, status, constant source.
// - Registers 4 to 15 are general-purpose storage.
// - Seven source modes; destinations only register, indexed, symbolic, absolute.
// - Non-flow operations are register operations plus operand addressing modes.
// - Twenty-seven instructions in three instruction word formats.
// - Instructions other than jumps, call and return work on word or byte data per their encoding.
// - Dual-operand result written back into the destination location, except compare and bit test.
// - Single-operand names destination; call pushes program counter then jumps.
// - Relative jumps, conditional or not; not-equal jumps only when zero is 0.
// - Autoincrement reads at register address, then adds 2 for words.
// - Peripherals and memory are reached over the data, address, control buses.
`timescale 1ns/100ps
`default_nettype none
module cpu_core (
	// Clock and reset
	input wire logic i_ref_clk,
	input wire logic i_resetn,
	// Memory and peripheral bus
	input wire logic [cpu_pkg::XLEN-1:0] i_mem_rdata,
	output logic [cpu_pkg::XLEN-1:0] o_mem_addr,
	output logic [cpu_pkg::XLEN-1:0] o_mem_wdata,
	output logic [1:0] o_mem_be,
	output logic o_mem_rd,
	output logic o_mem_wr
);
	import cpu_pkg::*;
	logic [15:0] rf [NREG];
	logic [15:0] next_rf [NREG];
	logic [15:0] ir, ea, src_val, next_ir, next_ea, next_src, next_addr, next_wdata;
	logic [1:0] next_be;
	logic next_rd, next_wr, fetch;
	state_e state, next_state;
	// Decode
	wire [15:0] instr = (state == S_EXEC) ? i_mem_rdata : ir;
	wire [15:0] pc = rf[REG_PC];
	wire [15:0] sp = rf[REG_SP];
	wire [15:0] sr = rf[REG_SR];
	wire is_jmp = instr[15:13] == JMP_PREFIX;
	wire is_f1 = instr[15:12] >= OP_MOVE;
	wire is_f2 = instr[15:10] == F2_PREFIX;
	wire [2:0] f2_opc = instr[9:7];
	wire is_reti = is_f2 && (f2_opc == F2_RETI);
	wire is_legal = is_f1 || (is_f2 && (f2_opc <= F2_CALL));
	wire [3:0] src_reg = is_f2 ? instr[3:0] : instr[11:8];
	wire [3:0] dst_reg = instr[3:0];
	wire [1:0] as = instr[5:4];
	wire ad = instr[7] && is_f1;
	wire bw = instr[6];
	wire [2:0] jcond = instr[12:10];
	wire is_cg = (src_reg == REG_CG) || ((src_reg == REG_SR) && as[1]);
	wire src_direct = (as == AS_REG) || is_cg;
	wire [15:0] cg_val = (src_reg == REG_SR) ? (as[0] ? CG_EIGHT : CG_FOUR) :
		(as == AS_REG) ? CG_ZERO : (as == AS_IDX) ? CG_ONE : (as == AS_IND) ? CG_TWO : CG_ALL;
	wire [15:0] opnd_direct = is_cg ? cg_val : rf[src_reg];
	wire [15:0] mem_byte = bw ? {8'h00, ea[0] ? i_mem_rdata[15:8] : i_mem_rdata[7:0]} :
		i_mem_rdata;
	wire [15:0] src_now = (state == S_EXEC) ? opnd_direct : (state == S_SRCM) ? mem_byte :
		src_val;
	wire [15:0] inc_step = (bw && (src_reg != REG_PC) && (src_reg != REG_SP)) ? STEP_BYTE :
		STEP_WORD;
	wire [15:0] src_base = (src_reg == REG_SR) ? CG_ZERO :
		(src_reg == REG_PC) ? pc - STEP_WORD : rf[src_reg];
	wire [15:0] dst_base = (dst_reg == REG_SR) ? CG_ZERO :
		(dst_reg == REG_PC) ? pc - STEP_WORD : rf[dst_reg];
	wire [15:0] sp_dec = sp - STEP_WORD;
	wire [15:0] jmp_off = {{5{instr[9]}}, instr[9:0], 1'b0};
	wire jmp_taken = (jcond == J_NE) ? !sr[SR_Z] : (jcond == J_EQ) ? sr[SR_Z] :
		(jcond == J_NC) ? !sr[SR_C] : (jcond == J_C) ? sr[SR_C] :
		(jcond == J_N) ? sr[SR_N] : (jcond == J_GE) ? !(sr[SR_N] ^ sr[SR_V]) :
		(jcond == J_L) ? (sr[SR_N] ^ sr[SR_V]) : 1'b1;
	wire after_src = ((state == S_EXEC) && !is_jmp && is_legal && !is_reti && src_direct) ||
		(state == S_SRCM);
	wire is_push = is_f2 && ((f2_opc == F2_PUSH) || (f2_opc == F2_CALL));
	wire is_call = is_f2 && (f2_opc == F2_CALL);
	wire exec_now = (after_src && (is_f1 ? !ad : !f2_opc[2])) || (state == S_DSTM);
	// Arithmetic unit
	wire [3:0] alu_op = is_f2 ? {2'b00, f2_opc[1:0]} : instr[15:12];
	wire [15:0] alu_dst = is_f2 ? src_now : (state == S_DSTM) ? mem_byte : rf[dst_reg];
	wire [15:0] alu_res;
	wire [3:0] alu_flags;
	wire alu_flag_we, alu_wb;
	wire [15:0] wdata_res = bw ? {alu_res[7:0], alu_res[7:0]} : alu_res;
	wire [1:0] be_res = bw ? (ea[0] ? BE_HIGH : BE_LOW) : BE_WORD;
	alu16 u_alu (
		.i_op(alu_op),
		.i_byte(bw),
		.i_carry(sr[SR_C]),
		.i_src(src_now),
		.i_dst(alu_dst),
		.o_res(alu_res),
		.o_flags(alu_flags),
		.o_flag_we(alu_flag_we),
		.o_wb(alu_wb)
	);
	// Sequencer
	always_comb begin
		next_rf = rf;
		next_state = state;
		next_addr = o_mem_addr;
		next_wdata = o_mem_wdata;
		next_be = o_mem_be;
		next_rd = 1'b0;
		next_wr = 1'b0;
		next_ir = ir;
		next_ea = ea;
		next_src = src_now;
		fetch = 1'b0;
		if (exec_now && alu_flag_we) begin
			next_rf[REG_SR][SR_N:SR_C] = alu_flags[2:0];
			next_rf[REG_SR][SR_V] = alu_flags[3];
		end
		case (state)
			S_FETCH: fetch = 1'b1;
			S_EXEC: begin
				next_ir = i_mem_rdata;
				if (is_reti) begin
					next_addr = sp;
					next_rd = 1'b1;
					next_rf[REG_SP] = sp + STEP_WORD;
					next_state = S_POPSR;
				end else if (is_jmp || !is_legal) begin
					next_rf[REG_PC] = (is_jmp && jmp_taken) ? pc + jmp_off : pc;
					fetch = 1'b1;
				end else if (as == AS_IDX && !is_cg) begin
					next_addr = pc;
					next_rd = 1'b1;
					next_rf[REG_PC] = pc + STEP_WORD;
					next_state = S_SRCX;
				end else if (!src_direct) begin
					next_addr = rf[src_reg];
					next_ea = rf[src_reg];
					next_rd = 1'b1;
					if (as == AS_INC) begin
						next_rf[src_reg] = rf[src_reg] + inc_step;
					end
					next_state = S_SRCM;
				end
			end
			S_SRCX: begin
				next_ea = i_mem_rdata + src_base;
				next_addr = i_mem_rdata + src_base;
				next_rd = 1'b1;
				next_state = S_SRCM;
			end
			S_DSTX: begin
				next_ea = i_mem_rdata + dst_base;
				next_addr = i_mem_rdata + dst_base;
				next_rd = 1'b1;
				next_state = S_DSTM;
			end
			S_DSTM: begin
				if (alu_wb) begin
					next_addr = ea;
					next_wdata = wdata_res;
					next_be = be_res;
					next_wr = 1'b1;
					next_state = S_FETCH;
				end else begin
					fetch = 1'b1;
				end
			end
			S_POPSR: begin
				next_rf[REG_SR] = i_mem_rdata;
				next_addr = sp;
				next_rd = 1'b1;
				next_rf[REG_SP] = sp + STEP_WORD;
				next_state = S_POPPC;
			end
			S_POPPC: begin
				next_rf[REG_PC] = i_mem_rdata;
				fetch = 1'b1;
			end
			default: ;
		endcase
		if (after_src) begin
			if (is_f1 && !ad) begin
				if (alu_wb && dst_reg != REG_CG) begin
					next_rf[dst_reg] = alu_res;
				end
				fetch = 1'b1;
			end else if (is_f1) begin
				next_addr = pc;
				next_rd = 1'b1;
				next_rf[REG_PC] = pc + STEP_WORD;
				next_state = S_DSTX;
			end else if (is_push) begin
				next_rf[REG_SP] = sp_dec;
				next_addr = sp_dec;
				next_wr = 1'b1;
				next_wdata = is_call ? pc : (bw ? {src_now[7:0], src_now[7:0]} : src_now);
				next_be = (bw && !is_call) ? BE_LOW : BE_WORD;
				next_rf[REG_PC] = is_call ? src_now : pc;
				next_state = S_FETCH;
			end else if (state == S_EXEC) begin
				if (!is_cg) begin
					next_rf[src_reg] = alu_res;
				end
				fetch = 1'b1;
			end else begin
				next_addr = ea;
				next_wdata = wdata_res;
				next_be = be_res;
				next_wr = 1'b1;
				next_state = S_FETCH;
			end
		end
		if (fetch) begin
			next_addr = next_rf[REG_PC];
			next_rd = 1'b1;
			next_rf[REG_PC] = next_rf[REG_PC] + STEP_WORD;
			next_state = S_EXEC;
		end
		next_rf[REG_CG] = RESET_REG;
	end
	always_ff @(posedge i_ref_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			rf <= '{default: RESET_REG};
			rf[REG_PC] <= RESET_PC;
			state <= S_FETCH;
			ir <= RESET_REG;
			ea <= RESET_REG;
			src_val <= RESET_REG;
		end else begin
			rf <= next_rf;
			state <= next_state;
			ir <= next_ir;
			ea <= next_ea;
			src_val <= next_src;
		end
	end
	always_ff @(posedge i_ref_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			o_mem_addr <= RESET_REG;
			o_mem_wdata <= RESET_REG;
			o_mem_be <= BE_WORD;
			o_mem_rd <= 1'b0;
			o_mem_wr <= 1'b0;
		end else begin
			o_mem_addr <= next_addr;
			o_mem_wdata <= next_wdata;
			o_mem_be <= next_be;
			o_mem_rd <= next_rd;
			o_mem_wr <= next_wr;
		end
	end
	// Checks
	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (!i_resetn);
	sequence call_reg_s;
		state == S_EXEC && is_call && src_direct;
	endsequence
	sequence push_return_s;
		o_mem_wr && o_mem_addr == $past(sp) - STEP_WORD && o_mem_wdata == $past(pc);
	endsequence
	sequence jump_target_s;
		state == S_EXEC && o_mem_rd && o_mem_addr == $past(src_val);
	endsequence
	a_regreg_one: assert property (
		(after_src && state == S_EXEC && is_f1 && !ad) |=> (state == S_EXEC && o_mem_rd))
		else $error("register operation took more than one cycle");
	a_pc_fetch: assert property (
		(state == S_EXEC) |-> (o_mem_rd && o_mem_addr == pc - STEP_WORD))
		else $error("program counter not one word past the fetch");
	a_const_zero: assert property (rf[REG_CG] == CG_ZERO)
		else $error("constant source register changed");
	a_gpr_write: assert property (
		(after_src && state == S_EXEC && is_f1 && !ad && alu_wb && dst_reg >= REG_GP_FIRST)
		|=> rf[$past(dst_reg)] == $past(alu_res))
		else $error("general register lost its result");
	a_autoinc_step: assert property (
		(state == S_EXEC && is_legal && !is_reti && !is_jmp && !is_cg && as == AS_INC &&
		!bw && src_reg > REG_PC) |=> (state == S_SRCM && o_mem_addr == $past(opnd_direct) &&
		rf[$past(src_reg)] == $past(opnd_direct) + STEP_WORD))
		else $error("autoincrement did not add two");
	a_jne_held: assert property (
		(state == S_EXEC && is_jmp && jcond == J_NE && sr[SR_Z]) |=> o_mem_addr == $past(pc))
		else $error("not-equal jump taken while zero set");
	a_call_push: assert property (call_reg_s |=> push_return_s ##1 jump_target_s)
		else $error("call did not push return address then jump");
	a_ext_word: assert property (
		(state == S_EXEC && is_legal && !is_reti && !is_jmp && !is_cg && as == AS_IDX)
		|=> (state == S_SRCX && o_mem_rd && o_mem_addr == $past(pc)))
		else $error("extension word not fetched");
	a_imm_step: assert property (
		(state == S_EXEC && is_legal && !is_reti && !is_jmp && as == AS_INC && src_reg == REG_PC)
		|=> (o_mem_addr == $past(pc) && pc == $past(pc) + STEP_WORD))
		else $error("immediate word not skipped");
	a_dst_write: assert property (
		(state == S_DSTM && alu_wb) |=> (o_mem_wr && o_mem_addr == $past(ea)))
		else $error("result not written to destination");
endmodule
`default_nettype wire

// *** src/cpu_pkg.sv ***
// Purpose: Shared constants for the 16-bit operand-mode processor core
// Assumes: Word-wide memory bus with byte enables, one-cycle read data
// Notes: Reset program counter value is a plain default
package cpu_pkg;
	localparam int XLEN = 16;
	localparam int NREG = 16;
	localparam logic [3:0] REG_PC = 4'h0;
	localparam logic [3:0] REG_SP = 4'h1;
	localparam logic [3:0] REG_SR = 4'h2;
	localparam logic [3:0] REG_CG = 4'h3;
	localparam logic [3:0] REG_GP_FIRST = 4'h4;
	localparam logic [15:0] RESET_PC = 16'h0000;
	localparam logic [15:0] RESET_REG = 16'h0000;
	localparam logic [15:0] STEP_WORD = 16'h0002;
	localparam logic [15:0] STEP_BYTE = 16'h0001;
	// Status bit positions
	localparam int SR_C = 0;
	localparam int SR_Z = 1;
	localparam int SR_N = 2;
	localparam int SR_V = 8;
	// Addressing mode field
	localparam logic [1:0] AS_REG = 2'h0;
	localparam logic [1:0] AS_IDX = 2'h1;
	localparam logic [1:0] AS_IND = 2'h2;
	localparam logic [1:0] AS_INC = 2'h3;
	// Constant source values
	localparam logic [15:0] CG_ZERO = 16'h0000;
	localparam logic [15:0] CG_ONE = 16'h0001;
	localparam logic [15:0] CG_TWO = 16'h0002;
	localparam logic [15:0] CG_FOUR = 16'h0004;
	localparam logic [15:0] CG_EIGHT = 16'h0008;
	localparam logic [15:0] CG_ALL = 16'hFFFF;
	// Operation codes: single-operand 0..3, dual-operand 4..F
	localparam logic [3:0] OP_RRC = 4'h0;
	localparam logic [3:0] OP_SWPB = 4'h1;
	localparam logic [3:0] OP_RRA = 4'h2;
	localparam logic [3:0] OP_SXT = 4'h3;
	localparam logic [3:0] OP_MOVE = 4'h4;
	localparam logic [3:0] OP_ADD = 4'h5;
	localparam logic [3:0] OP_ADDC = 4'h6;
	localparam logic [3:0] OP_SUBC = 4'h7;
	localparam logic [3:0] OP_SUB = 4'h8;
	localparam logic [3:0] OP_CMP = 4'h9;
	localparam logic [3:0] OP_DADD = 4'hA;
	localparam logic [3:0] OP_BIT = 4'hB;
	localparam logic [3:0] OP_BIC = 4'hC;
	localparam logic [3:0] OP_BIS = 4'hD;
	localparam logic [3:0] OP_XOR = 4'hE;
	localparam logic [3:0] OP_AND = 4'hF;
	// Single-operand format and jump prefix
	localparam logic [5:0] F2_PREFIX = 6'h04;
	localparam logic [2:0] F2_PUSH = 3'h4;
	localparam logic [2:0] F2_CALL = 3'h5;
	localparam logic [2:0] F2_RETI = 3'h6;
	localparam logic [2:0] JMP_PREFIX = 3'h1;
	// Jump conditions
	localparam logic [2:0] J_NE = 3'h0;
	localparam logic [2:0] J_EQ = 3'h1;
	localparam logic [2:0] J_NC = 3'h2;
	localparam logic [2:0] J_C = 3'h3;
	localparam logic [2:0] J_N = 3'h4;
	localparam logic [2:0] J_GE = 3'h5;
	localparam logic [2:0] J_L = 3'h6;
	localparam logic [2:0] J_MP = 3'h7;
	localparam logic [1:0] BE_WORD = 2'h3;
	localparam logic [1:0] BE_LOW = 2'h1;
	localparam logic [1:0] BE_HIGH = 2'h2;
	typedef enum logic [2:0] {
		S_FETCH = 3'b000,
		S_EXEC = 3'b001,
		S_SRCX = 3'b010,
		S_SRCM = 3'b011,
		S_DSTX = 3'b100,
		S_DSTM = 3'b101,
		S_POPSR = 3'b110,
		S_POPPC = 3'b111
	} state_e;
endpackage
